// ===== src/adcc_regs.vh
// Overview of operation
// R01 - The converter clock is the system clock divided by a power of two picked by a three-bit field; at divide by one conv_clock stays low.
// R02 - Setting the power enable bit powers up the converter so that conversions can run.
// R03 - A four-bit source field picks external or internal inputs, and a channel field picks the pin.
// R04 - An internal source disconnects the external channel path whatever the channel field holds.
// R05 - A two-bit field picks the reference, and a separate bit picks the amplifier input.
// R06 - A format bit picks how the 12-bit result lies across the high and low result registers.
// R07 - Completion raises the interrupt only when both global and converter enables are high.
// R08 - Software pulses start low-high-low; the rise resets the converter, the fall starts it.
// R09 - Busy reads high during a conversion and low at completion, after which the result is valid.
// R10 - Clearing power enable switches the converter circuits off whatever their inputs.
// R11 - The result is 12 bits wide, with all ones as the full-scale code.
// R12 - One code step is the reference divided by 4096, so input equals code times step.
// R13 - The interrupt flag stays pending until software clears it.
// R14 - A conversion takes 16 converter clocks: 4 of sampling, then 12 of conversion.
// R15 - Source codes map to external, supply ratios, amplifier ratios or ground.
// R16 - Reference code 00 is supply, 01 the reference pin, 1x the amplifier output.
// R17 - Busy rises on the start fall and the interrupt flag sets when busy clears.
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH

`define ADCC_ADDR_CTRL0      3'h0
`define ADCC_ADDR_CTRL1      3'h1
`define ADCC_ADDR_CTRL2      3'h2
`define ADCC_ADDR_RES_HIGH   3'h3
`define ADCC_ADDR_RES_LOW    3'h4
`define ADCC_ADDR_IRQ_STAT   3'h5
`define ADCC_ADDR_IRQ_EN     3'h6
`define ADCC_ADDR_IRQ_CLR    3'h7

`define ADCC_C0_START        7
`define ADCC_C0_BUSY         6
`define ADCC_C0_POWER        5
`define ADCC_C0_FORMAT       4
`define ADCC_C0_CH_MSB       3
`define ADCC_C1_SRC_MSB      7
`define ADCC_C1_SRC_LSB      4
`define ADCC_C1_CLK_MSB      2
`define ADCC_C2_PGA_EN       3
`define ADCC_C2_AMP_SEL      2
`define ADCC_C2_REF_MSB      1
`define ADCC_IRQ_DONE        0
`define ADCC_IRQ_GLOBAL      7

`define ADCC_RST_CTRL0       8'h00
`define ADCC_RST_CTRL1       8'h00
`define ADCC_RST_CTRL2       8'h00
`define ADCC_RST_IRQ_EN      8'h00

`define ADCC_RES_W           12
`define ADCC_FULL_SCALE      12'hFFF
`define ADCC_SAMPLE_CLKS     4'h4
`define ADCC_CONVERT_CLKS    4'hC

`define ADCC_ROUTE_EXT       2'h0
`define ADCC_ROUTE_SUPPLY    2'h1
`define ADCC_ROUTE_AMP       2'h2
`define ADCC_ROUTE_GND       2'h3

`define ADCC_REF_SUPPLY      2'h0
`define ADCC_REF_PIN         2'h1
`define ADCC_REF_AMP         2'h2

`endif

// ===== src/adcc_clkdiv.v
`timescale 1ns/1ps
module adcc_clkdiv (
   input  wire       mclk,
   input  wire       rst_n,
   input  wire       restart,
   input  wire [2:0] div_sel,
   output reg        tick,
   output reg        conv_clock
);

   reg  [6:0] count;
   wire [6:0] last;
   wire [6:0] half;

   // period is 2**div_sel system clocks
   assign last = (7'h01 << div_sel) - 7'h01;
   assign half = last >> 1;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count      <= 7'h00;
         tick       <= 1'b0;
         conv_clock <= 1'b0;
      end else if (restart) begin
         // realigned so the first period after start is a whole one
         count      <= 7'h00;
         tick       <= 1'b0;
         conv_clock <= 1'b0;
      end else begin
         count      <= (count >= last) ? 7'h00 : count + 7'h01;
         tick       <= (count >= last);
         conv_clock <= (count >= half) && (count < last);
      end
   end

endmodule

// ===== src/adcc_top.v
`timescale 1ns/1ps
`include "adcc_regs.vh"
module adcc_top (
   input  wire        mclk,
   input  wire        reset_n,
   input  wire [2:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata,
   output wire        irq,
   input  wire        comp_high,
   output reg         conv_power_on,
   output wire        conv_clock,
   output reg         conv_reset,
   output reg         conv_sampling,
   output reg  [11:0] dac_code,
   output reg         ext_channel_enable,
   output reg  [3:0]  external_channel_select,
   output reg  [1:0]  input_route,
   output reg  [1:0]  input_ratio,
   output reg  [1:0]  reference_route,
   output reg         amplifier_enable,
   output reg         amplifier_input_select
);

   localparam ST_IDLE    = 2'h0;
   localparam ST_SAMPLE  = 2'h1;
   localparam ST_CONVERT = 2'h2;

   reg         rst_meta;
   reg         rst_sync;
   wire        rst_n;

   reg         start_bit;
   reg         start_prev;
   reg         converter_power_enable;
   reg         result_format_select;
   reg  [3:0]  channel_field;
   reg  [3:0]  input_source_select;
   reg  [2:0]  conv_clock_select;
   reg         pga_enable_bit;
   reg         amp_sel_bit;
   reg  [1:0]  reference_source_select;
   reg         converter_irq_enable;
   reg         global_irq_enable;
   reg         converter_irq_flag;
   reg         conversion_busy_flag;
   reg  [1:0]  state;
   reg  [3:0]  period_cnt;
   reg  [11:0] sar;
   reg  [11:0] bit_mask;
   reg  [11:0] result;
   reg         done;

   reg  [1:0]  next_state;
   reg  [3:0]  next_period_cnt;
   reg  [11:0] next_sar;
   reg  [11:0] next_bit_mask;
   reg  [11:0] next_result;
   reg         next_busy;
   reg         next_done;
   reg  [1:0]  next_route;
   reg  [1:0]  next_ratio;
   reg  [7:0]  next_rdata;

   wire        wr_ctrl0;
   wire        wr_ctrl1;
   wire        wr_ctrl2;
   wire        wr_irq_en;
   wire        wr_irq_clr;
   wire        start_rise;
   wire        start_fall;
   wire        tick;
   wire [7:0]  res_high;
   wire [7:0]  res_low;

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   assign rst_n = rst_sync;

   assign wr_ctrl0   = reg_wr && (reg_addr == `ADCC_ADDR_CTRL0);
   assign wr_ctrl1   = reg_wr && (reg_addr == `ADCC_ADDR_CTRL1);
   assign wr_ctrl2   = reg_wr && (reg_addr == `ADCC_ADDR_CTRL2);
   assign wr_irq_en  = reg_wr && (reg_addr == `ADCC_ADDR_IRQ_EN);
   assign wr_irq_clr = reg_wr && (reg_addr == `ADCC_ADDR_IRQ_CLR);

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         start_bit               <= 1'b0;
         converter_power_enable  <= 1'b0;
         result_format_select    <= 1'b0;
         channel_field           <= 4'h0;
         input_source_select     <= 4'h0;
         conv_clock_select       <= 3'h0;
         pga_enable_bit          <= 1'b0;
         amp_sel_bit             <= 1'b0;
         reference_source_select <= 2'h0;
         converter_irq_enable    <= 1'b0;
         global_irq_enable       <= 1'b0;
      end else begin
         if (wr_ctrl0) begin
            start_bit              <= reg_wdata[`ADCC_C0_START];
            // power enable steers the core supply and conversion gating
            converter_power_enable <= reg_wdata[`ADCC_C0_POWER];
            result_format_select   <= reg_wdata[`ADCC_C0_FORMAT];
            channel_field          <= reg_wdata[`ADCC_C0_CH_MSB:0];
         end
         if (wr_ctrl1) begin
            input_source_select <= reg_wdata[`ADCC_C1_SRC_MSB:`ADCC_C1_SRC_LSB];
            conv_clock_select   <= reg_wdata[`ADCC_C1_CLK_MSB:0];
         end
         if (wr_ctrl2) begin
            pga_enable_bit          <= reg_wdata[`ADCC_C2_PGA_EN];
            amp_sel_bit             <= reg_wdata[`ADCC_C2_AMP_SEL];
            reference_source_select <= reg_wdata[`ADCC_C2_REF_MSB:0];
         end
         if (wr_irq_en) begin
            converter_irq_enable <= reg_wdata[`ADCC_IRQ_DONE];
            global_irq_enable    <= reg_wdata[`ADCC_IRQ_GLOBAL];
         end
      end
   end

   // R08 start edges
   assign start_rise = start_bit && !start_prev;
   assign start_fall = !start_bit && start_prev;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         start_prev <= 1'b0;
      end else begin
         start_prev <= start_bit;
      end
   end

   // R01 converter clock divider
   adcc_clkdiv u_clkdiv (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .restart    (start_fall),
      .div_sel    (conv_clock_select),
      .tick       (tick),
      .conv_clock (conv_clock)
   );

   always @* begin
      next_state      = state;
      next_period_cnt = period_cnt;
      next_sar        = sar;
      next_bit_mask   = bit_mask;
      next_result     = result;
      next_busy       = conversion_busy_flag;
      next_done       = 1'b0;
      case (state)
         ST_IDLE: begin
            // R17 busy rises on start fall
            if (start_fall && converter_power_enable) begin
               next_state      = ST_SAMPLE;
               next_period_cnt = 4'h0;
               next_sar        = 12'h000;
               next_bit_mask   = 12'h800;
               next_busy       = 1'b1;
            end
         end
         ST_SAMPLE: begin
            // R14 four sampling periods
            if (tick) begin
               if (period_cnt == `ADCC_SAMPLE_CLKS - 4'h1) begin
                  next_state      = ST_CONVERT;
                  next_period_cnt = 4'h0;
               end else begin
                  next_period_cnt = period_cnt + 4'h1;
               end
            end
         end
         ST_CONVERT: begin
            // R14 twelve conversion periods, one bit each, msb first
            if (tick) begin
               next_sar        = comp_high ? (sar | bit_mask) : sar;
               next_bit_mask   = bit_mask >> 1;
               next_period_cnt = period_cnt + 4'h1;
               if (period_cnt == `ADCC_CONVERT_CLKS - 4'h1) begin
                  // R11 code lands in 12 bits
                  next_result = comp_high ? (sar | bit_mask) : sar;
                  next_state  = ST_IDLE;
                  // R09 busy falls at completion
                  next_busy   = 1'b0;
                  next_done   = 1'b1;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_busy  = 1'b0;
         end
      endcase
      // R08 rise resets the converter
      if (start_rise || !converter_power_enable) begin
         next_state      = ST_IDLE;
         next_period_cnt = 4'h0;
         next_sar        = 12'h000;
         next_bit_mask   = 12'h000;
         next_busy       = 1'b0;
         next_done       = 1'b0;
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state                <= ST_IDLE;
         period_cnt           <= 4'h0;
         sar                  <= 12'h000;
         bit_mask             <= 12'h000;
         result               <= 12'h000;
         conversion_busy_flag <= 1'b0;
         done                 <= 1'b0;
      end else begin
         state                <= next_state;
         period_cnt           <= next_period_cnt;
         sar                  <= next_sar;
         bit_mask             <= next_bit_mask;
         result               <= next_result;
         conversion_busy_flag <= next_busy;
         done                 <= next_done;
      end
   end

   // R13 flag held until cleared; a completion in the clear cycle wins
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         converter_irq_flag <= 1'b0;
      end else if (done) begin
         converter_irq_flag <= 1'b1;
      end else if (wr_irq_clr && reg_wdata[`ADCC_IRQ_DONE]) begin
         converter_irq_flag <= 1'b0;
      end
   end

   // R07 both enables gate the request
   assign irq = converter_irq_flag && converter_irq_enable && global_irq_enable;

   // R15 source decode
   always @* begin
      next_ratio = 2'h0;
      case (input_source_select)
         4'h1, 4'h2, 4'h3: begin
            next_route = `ADCC_ROUTE_SUPPLY;
            next_ratio = input_source_select[1:0] - 2'h1;
         end
         4'h5, 4'h6, 4'h7: begin
            next_route = `ADCC_ROUTE_AMP;
            next_ratio = input_source_select[1:0] - 2'h1;
         end
         4'h8, 4'h9, 4'hA, 4'hB: begin
            next_route = `ADCC_ROUTE_GND;
         end
         default: begin
            next_route = `ADCC_ROUTE_EXT;
         end
      endcase
   end

   // core control outputs held in flops so the analog side sees clean levels
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         conv_power_on           <= 1'b0;
         conv_reset              <= 1'b0;
         conv_sampling           <= 1'b0;
         dac_code                <= 12'h000;
         ext_channel_enable      <= 1'b0;
         external_channel_select <= 4'h0;
         input_route             <= `ADCC_ROUTE_GND;
         input_ratio             <= 2'h0;
         reference_route         <= `ADCC_REF_SUPPLY;
         amplifier_enable        <= 1'b0;
         amplifier_input_select  <= 1'b0;
      end else begin
         // R02 power up
         // R10 power off gates sampling, the external path, the input route and the amplifier enable
         conv_power_on          <= converter_power_enable;
         conv_reset             <= start_bit;
         conv_sampling          <= converter_power_enable && (next_state == ST_SAMPLE);
         dac_code               <= next_sar | next_bit_mask;
         // R03 channel field feeds the external mux
         external_channel_select <= channel_field;
         // R04 internal source cuts the external path
         ext_channel_enable     <= converter_power_enable && (next_route == `ADCC_ROUTE_EXT);
         input_route            <= converter_power_enable ? next_route : `ADCC_ROUTE_GND;
         input_ratio            <= next_ratio;
         // R16 reference decode
         if (reference_source_select[1]) begin
            reference_route <= `ADCC_REF_AMP;
         end else if (reference_source_select[0]) begin
            reference_route <= `ADCC_REF_PIN;
         end else begin
            reference_route <= `ADCC_REF_SUPPLY;
         end
         // R05 amplifier enable and input pick
         amplifier_enable       <= converter_power_enable && pga_enable_bit;
         amplifier_input_select <= amp_sel_bit;
      end
   end

   // R06 result arrangement; R12 code is input over reference times 4096
   assign res_high = result_format_select ? {4'h0, result[11:8]} : result[11:4];
   assign res_low  = result_format_select ? result[7:0] : {result[3:0], 4'h0};

   always @* begin
      case (reg_addr)
         `ADCC_ADDR_CTRL0: begin
            next_rdata = {start_bit, conversion_busy_flag, converter_power_enable,
                          result_format_select, channel_field};
         end
         `ADCC_ADDR_CTRL1: begin
            next_rdata = {input_source_select, 1'b0, conv_clock_select};
         end
         `ADCC_ADDR_CTRL2: begin
            next_rdata = {4'h0, pga_enable_bit, amp_sel_bit, reference_source_select};
         end
         `ADCC_ADDR_RES_HIGH: begin
            next_rdata = res_high;
         end
         `ADCC_ADDR_RES_LOW: begin
            next_rdata = res_low;
         end
         `ADCC_ADDR_IRQ_STAT: begin
            next_rdata = {7'h00, converter_irq_flag};
         end
         `ADCC_ADDR_IRQ_EN: begin
            next_rdata = {global_irq_enable, 6'h00, converter_irq_enable};
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   // R09 busy visible in the first control register
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule

// ===== tb/adcc_asserts.sv
`timescale 1ns/1ps
module adcc_asserts (
   input wire logic        mclk,
   input wire logic        reset_n,
   input wire logic [2:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        irq,
   input wire logic        conv_power_on,
   input wire logic        conv_reset,
   input wire logic        conv_sampling,
   input wire logic        ext_channel_enable,
   input wire logic [3:0]  external_channel_select,
   input wire logic [1:0]  input_route,
   input wire logic        amplifier_enable
);
   logic [7:0] en_sh;
   logic [2:0] sel_sh;
   logic [9:0] samp_cnt;
   function automatic logic [1:0] route_of(input logic [3:0] s);
      if (s[3:2] == 2'b10) return 2'h3;
      if (s[1:0] == 2'b00 || s[3:2] == 2'b11) return 2'h0;
      return s[2] ? 2'h2 : 2'h1;
   endfunction
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         en_sh    <= 8'h00;
         sel_sh   <= 3'h0;
         samp_cnt <= 10'h000;
      end else begin
         if (reg_wr && reg_addr == 3'h6) en_sh <= reg_wdata;
         if (reg_wr && reg_addr == 3'h1) sel_sh <= reg_wdata[2:0];
         samp_cnt <= conv_sampling ? samp_cnt + 10'h001 : 10'h000;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   property p_rdata_idle; reg_rdata != 8'h00 |-> $past(reg_rd); endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside read slot");
   sequence s_c0_wr; reg_wr && reg_addr == 3'h0 ##1 !(reg_wr && reg_addr == 3'h0); endsequence
   property p_power; s_c0_wr |-> ##1 conv_power_on == $past(reg_wdata[5], 2); endproperty
   a_power: assert property (p_power)
      else $error("power output does not follow control bit");
   property p_start; s_c0_wr |-> ##1 conv_reset == $past(reg_wdata[7], 2); endproperty
   a_start: assert property (p_start)
      else $error("converter reset does not follow start bit");
   property p_chan; s_c0_wr |-> ##1 external_channel_select == $past(reg_wdata[3:0], 2);
   endproperty
   a_chan: assert property (p_chan)
      else $error("channel output does not follow field");
   property p_route;
      reg_wr && reg_addr == 3'h1 && conv_power_on ##1 !(reg_wr && reg_addr[2:1] == 2'b00)
         |-> ##1 input_route == route_of($past(reg_wdata[7:4], 2));
   endproperty
   a_route: assert property (p_route)
      else $error("input route wrong for source code");
   property p_ext_off; input_route != 2'h0 |-> !ext_channel_enable; endproperty
   a_ext_off: assert property (p_ext_off)
      else $error("external path on with internal source");
   property p_amp_power; amplifier_enable |-> conv_power_on; endproperty
   a_amp_power: assert property (p_amp_power)
      else $error("amplifier on while converter off");
   property p_irq_gate; irq |-> en_sh[7] && en_sh[0]; endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt without both enables");
   property p_flag_hold; irq && !(reg_wr && reg_addr[2:1] == 2'b11) |=> irq; endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("interrupt dropped without clear");
   property p_samp_len;
      // sampling flag rises on the start-fall edge, one cycle ahead of the first period
      $fell(conv_sampling) && !conv_reset && conv_power_on
         |-> samp_cnt == (10'h004 << sel_sh) + 10'h001;
   endproperty
   a_samp_len: assert property (p_samp_len)
      else $error("sampling phase length wrong");
endmodule

// ===== tb/adcc_analog_model.sv
`timescale 1ns/1ps
module adcc_analog_model (
   input  wire logic        mclk,
   input  wire logic        conv_power_on,
   input  wire logic        ext_channel_enable,
   input  wire logic [3:0]  external_channel_select,
   input  wire logic [1:0]  input_route,
   input  wire logic [1:0]  input_ratio,
   input  wire logic [11:0] dac_code,
   input  wire logic [11:0] ext_level,
   input  wire logic [11:0] amp_level,
   output logic             comp_high
);
   logic        junk = 1'b0;
   logic [11:0] level;
   // floating nodes toggle so a stray read never looks settled
   always @(posedge mclk) junk <= ~junk;
   always_comb begin
      case (input_route)
         2'h0: level = ext_level;
         2'h1: level = 12'hFFF >> input_ratio;
         2'h2: level = amp_level >> input_ratio;
         default: level = 12'h000;
      endcase
      if (!conv_power_on || (input_route == 2'h0 &&
          (!ext_channel_enable || external_channel_select > 4'hB))) begin
         comp_high = junk;
      end else begin
         comp_high = level >= dac_code;
      end
   end
endmodule

// ===== tb/adc_conversion_control_tb_top.sv
`timescale 1ns/1ps
module adc_conversion_control_tb_top;
   logic mclk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, comp_high;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, d, hi, lo;
   logic [11:0] ext_level = 12'h000, amp_level = 12'h000, dac_code;
   logic irq, conv_power_on, conv_clock, conv_reset, conv_sampling, ext_channel_enable;
   logic amplifier_enable, amplifier_input_select;
   logic [3:0] external_channel_select;
   logic [1:0] input_route, input_ratio, reference_route;
   int miscompares = 0, checked = 0, cyc = 0;
   int rises = 0;
   logic clk_q = 1'b0;
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) cyc++;
   // one converter clock rise per period when div_sel is nonzero, none at divide by one
   always @(posedge mclk) begin
      clk_q <= conv_clock;
      if (conv_clock && !clk_q) rises++;
   end
   adcc_top dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .comp_high(comp_high), .conv_power_on(conv_power_on), .conv_clock(conv_clock),
      .conv_reset(conv_reset), .conv_sampling(conv_sampling), .dac_code(dac_code),
      .ext_channel_enable(ext_channel_enable), .external_channel_select(external_channel_select),
      .input_route(input_route), .input_ratio(input_ratio), .reference_route(reference_route),
      .amplifier_enable(amplifier_enable), .amplifier_input_select(amplifier_input_select));
   adcc_analog_model u_model (.mclk(mclk), .conv_power_on(conv_power_on),
      .ext_channel_enable(ext_channel_enable), .external_channel_select(external_channel_select),
      .input_route(input_route), .input_ratio(input_ratio), .dac_code(dac_code),
      .ext_level(ext_level), .amp_level(amp_level), .comp_high(comp_high));
   task automatic tally_and_finish();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   function automatic logic [11:0] exp_code(input logic [3:0] s, input logic [11:0] e, a);
      logic [1:0] k;
      k = s[1:0] - 2'h1;
      if (s[3:2] == 2'b10) return 12'h000;
      if (s[1:0] == 2'b00 || s[3:2] == 2'b11) return e;
      return s[2] ? a >> k : 12'hFFF >> k;
   endfunction
   function automatic logic [15:0] pack(input logic [11:0] r, input logic f);
      return f ? {4'h0, r} : {r, 4'h0};
   endfunction
   task automatic convert(input int i);
      logic [3:0] src;
      logic [3:0] ch;
      logic [7:0] c2, en;
      logic [2:0] sel;
      logic fmt;
      int t0, n, r0;
      // every source code once over the sixteen tests
      src = 4'(64'hBA9F_EDC4_8765_3210 >> (4 * i));
      sel = i[1:0];
      en = 8'(32'h0080_0181 >> (8 * i[3:2]));
      ch = 4'($urandom % 12);
      fmt = 1'($urandom);
      c2 = 8'($urandom % 16);
      ext_level <= 12'($urandom);
      amp_level <= 12'($urandom);
      wr(3'h7, 8'h01);
      wr(3'h6, en);
      wr(3'h1, {src, 1'b0, sel});
      wr(3'h2, c2);
      wr(3'h0, {3'b001, fmt, ch});
      wr(3'h0, {3'b101, fmt, ch});
      wr(3'h0, {3'b001, fmt, ch});
      t0 = cyc;
      r0 = rises;
      @(posedge mclk);
      rd(3'h0, d);
      chk("busy after start", 16'h1, d[6]);
      n = 0;
      do begin
         rd(3'h0, d);
         n++;
      end while (d[6] === 1'b1 && n < 300);
      chk("conversion time in range", 16'h1, (cyc - t0 >= 16 << sel) && (cyc - t0 <= (16 << sel) + 8));
      r0 = rises - r0;
      chk("converter clock rises", 16'h1, sel == 3'h0 ? r0 == 0 : r0 inside {[15:18]});
      repeat (2) @(posedge mclk);
      #1;
      chk("irq gated by enables", en == 8'h81, irq);
      rd(3'h5, d);
      chk("flag pending", 16'h1, d);
      rd(3'h3, hi);
      rd(3'h4, lo);
      chk("result", pack(exp_code(src, ext_level, amp_level), fmt), {hi, lo});
      wr(3'h3, ~hi);
      rd(3'h3, d);
      chk("result read only", hi, d);
      chk("external path", src[3:2] != 2'b10 && (src[1:0] == 2'b00 || src[3:2] == 2'b11), ext_channel_enable);
      chk("reference", c2[1] ? 16'h2 : c2[1:0], reference_route);
      chk("amplifier", c2[3:2], {amplifier_enable, amplifier_input_select});
      wr(3'h6, 8'h81);
      #1;
      chk("stale flag raises irq", 16'h1, irq);
      wr(3'h7, 8'h01);
      #1;
      chk("irq cleared", 16'h0, irq);
      $display("conversion test %0d done", i);
   endtask
   initial begin
      void'($urandom(32'hb8b99e56));
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      for (int a = 0; a < 8; a++) begin
         rd(3'(a), d);
         if (a < 3 || a > 5) chk("reset value", 16'h0, d);
      end
      $display("reset test done");
      for (int i = 0; i < 16; i++) convert(i);
      wr(3'h1, 8'h03);
      wr(3'h0, 8'h20);
      wr(3'h0, 8'hA0);
      wr(3'h0, 8'h20);
      repeat (60) @(posedge mclk);
      wr(3'h0, 8'hA0);
      repeat (3) @(posedge mclk);
      rd(3'h0, d);
      chk("busy after abort", 16'h0, d[6]);
      repeat (200) @(posedge mclk);
      rd(3'h5, d);
      chk("no flag after abort", 16'h0, d);
      wr(3'h0, 8'h00);
      repeat (3) @(posedge mclk);
      #1;
      chk("power off outputs", 16'h0600, {conv_power_on, input_route, 8'h00, amplifier_enable});
      wr(3'h0, 8'h80);
      wr(3'h0, 8'h00);
      @(posedge mclk);
      rd(3'h0, d);
      chk("start ignored unpowered", 16'h0, d[6]);
      $display("abort test done");
      tally_and_finish();
   end
   initial begin
      #200000;
      miscompares++;
      tally_and_finish();
   end
endmodule
bind adcc_top adcc_asserts u_chk (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
   .conv_power_on(conv_power_on), .conv_reset(conv_reset), .conv_sampling(conv_sampling),
   .ext_channel_enable(ext_channel_enable), .external_channel_select(external_channel_select),
   .input_route(input_route), .amplifier_enable(amplifier_enable));
